//--- src/tbbc_ctrl.sv
// 10 Mb/s test pattern, heartbeat/jabber and packet self-test control block
`timescale 1ns/1ps
module tbbc_ctrl
    import tbbc_pkg::*;
#(
    parameter int ERR_W     = 8,
    parameter int SEQ_CYC   = TBBC_SEQ_CYC,
    parameter int GAP_LONG  = TBBC_GAP_LONG_CYC,
    parameter int GAP_SHORT = TBBC_GAP_SHORT_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        ce,
    // register port from the management interface logic
    input  wire logic        mgmt_wr,
    input  wire logic        mgmt_rd,
    input  wire logic [4:0]  mgmt_addr,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata_q,
    // port operating mode
    input  wire logic        speed_100,
    input  wire logic        full_duplex,
    // main self-test controls and receive checker
    input  wire logic        selftest_run,
    input  wire logic        selftest_start,
    input  wire logic        rx_nibble_err,
    // outputs to the 10 Mb/s transmit path
    output logic             sqe_enable_q,
    output logic             jabber_enable_q,
    output logic             selftest_nonstop_tx_q,
    output logic             pattern_send_q,
    output logic [1:0]       pattern_kind_q
);
    logic [2:0]       sc_q;
    logic [5:0]       dt_q;
    logic [ERR_W-1:0] selftest_nibble_err_cnt_q;
    logic [9:0]       low_run_q;
    logic [9:0]       high_run_q;
    logic             sqe_pulse_off;
    logic             long_tx_guard_off;
    logic             selftest_nonstop_tx;
    logic             driver_pattern_on;
    logic             pattern_gap_sel;
    logic [1:0]       driver_pattern_choice;

    assign long_tx_guard_off     = sc_q[TBBC_SC_GUARD_OFF];
    assign sqe_pulse_off         = sc_q[TBBC_SC_SQE_OFF];
    assign driver_pattern_choice = dt_q[TBBC_DT_CHOICE_LO +: 2];
    assign pattern_gap_sel       = dt_q[TBBC_DT_GAP_SEL];
    assign driver_pattern_on     = dt_q[TBBC_DT_PATT_ON];
    assign selftest_nonstop_tx   = dt_q[TBBC_DT_NONSTOP];

    // pick out the one register an access hits
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction

    // control writes; only bits 2:0 of the status register and bits 5:0 of the driver test register are held
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sc_q <= TBBC_SC_RESET;
            dt_q <= TBBC_DT_RESET;
        end else if (ce && mgmt_wr) begin
            if (hit(mgmt_addr, TBBC_OFS_TENBASE_SC)) begin
                // reserved bit stored as written; software keeps it one
                sc_q <= mgmt_wdata[2:0];
            end
            if (hit(mgmt_addr, TBBC_OFS_DRV_TEST)) begin
                dt_q <= mgmt_wdata[5:0];
            end
        end
    end

    // readback registered so the port comes from a flip-flop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mgmt_rdata_q <= TBBC_RDATA_RESET;
        end else if (ce && mgmt_rd) begin
            if (hit(mgmt_addr, TBBC_OFS_TENBASE_SC)) begin
                mgmt_rdata_q <= {13'h0000, sc_q};
            end else if (hit(mgmt_addr, TBBC_OFS_DRV_TEST)) begin
                mgmt_rdata_q <= {selftest_nibble_err_cnt_q, 2'h0, dt_q};
            end else begin
                mgmt_rdata_q <= TBBC_RDATA_RESET;
            end
        end
    end

    // heartbeat only ever runs at 10 Mb/s half duplex
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sqe_enable_q <= 1'b0;
        end else if (ce) begin
            sqe_enable_q <= !speed_100 && !full_duplex
                            && !sqe_pulse_off;
        end
    end

    // jabber guard; the bit is meaningless at 100 Mb/s so guard reads off there
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            jabber_enable_q <= 1'b0;
        end else if (ce) begin
            jabber_enable_q <= !speed_100 && !long_tx_guard_off;
        end
    end

    // nonstop random stream needs the main self-test running as well;
    // at 10 Mb/s the jabber guard would cut it unless software set the off bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            selftest_nonstop_tx_q <= 1'b0;
        end else if (ce) begin
            selftest_nonstop_tx_q <= selftest_nonstop_tx && selftest_run;
        end
    end

    // errored nibble counter: restart clears, top value sticks
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            selftest_nibble_err_cnt_q <= '0;
        end else if (ce) begin
            if (selftest_start) begin
                selftest_nibble_err_cnt_q <= '0;
            end else if (selftest_run && rx_nibble_err
                         && selftest_nibble_err_cnt_q != '1) begin
                selftest_nibble_err_cnt_q <= selftest_nibble_err_cnt_q + 1'b1;
            end
        end
    end

    // helper for the gap checks: length of the current low run while enabled
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            low_run_q <= '0;
        end else if (ce) begin
            if (!driver_pattern_on || pattern_send_q) begin
                low_run_q <= '0;
            end else if (low_run_q != '1) begin
                low_run_q <= low_run_q + 1'b1;
            end
        end
    end

    // helper for the burst check: length of the current high run while enabled
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            high_run_q <= '0;
        end else if (ce) begin
            if (!driver_pattern_on || !pattern_send_q) begin
                high_run_q <= '0;
            end else if (high_run_q != '1) begin
                high_run_q <= high_run_q + 1'b1;
            end
        end
    end

    // pattern burst and gap timing lives in its own sequencer
    tbbc_pattern_seq #(
        .SEQ_CYC   (SEQ_CYC),
        .GAP_LONG  (GAP_LONG),
        .GAP_SHORT (GAP_SHORT)
    ) u_seq (
        .clk_sys               (clk_sys),
        .arst_n                (arst_n),
        .ce                    (ce),
        .driver_pattern_on     (driver_pattern_on),
        .pattern_gap_sel       (pattern_gap_sel),
        .driver_pattern_choice (driver_pattern_choice),
        .pattern_send_q        (pattern_send_q),
        .pattern_kind_q        (pattern_kind_q)
    );

    // checks; run counters use the parameters so shortened gaps check too
    // gap over: a counted low run, then the next burst starts
    sequence s_gap_end;
        (!pattern_send_q && low_run_q != 10'h000) ##1 pattern_send_q;
    endsequence

    // burst over naturally: pattern still enabled when the line drops
    sequence s_burst_end;
        (pattern_send_q && high_run_q != 10'h000) ##1 (!pattern_send_q && driver_pattern_on);
    endsequence

    AST_SQE_FAST_FULL: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && (speed_100 || full_duplex)) |=> !sqe_enable_q)
        else $error("heartbeat on at 100M or full duplex");
    AST_SQE_OFF_BIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && !speed_100 && !full_duplex) |=> (sqe_enable_q == !$past(sqe_pulse_off)))
        else $error("heartbeat does not follow off bit");
    AST_JABBER: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && !speed_100) |=> (jabber_enable_q == !$past(long_tx_guard_off)))
        else $error("jabber guard does not follow off bit");
    AST_NONSTOP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce |=> (selftest_nonstop_tx_q == $past(selftest_nonstop_tx && selftest_run)))
        else $error("nonstop transmit wrong");
    AST_CNT_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && selftest_start) |=> selftest_nibble_err_cnt_q == '0)
        else $error("error count not cleared on restart");
    AST_CNT_STICK: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (selftest_nibble_err_cnt_q == '1 && !selftest_start) |=>
        selftest_nibble_err_cnt_q == '1)
        else $error("error count wrapped");
    AST_CNT_INC: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && !selftest_start && selftest_run && rx_nibble_err
         && selftest_nibble_err_cnt_q != '1) |=>
        selftest_nibble_err_cnt_q == $past(selftest_nibble_err_cnt_q) + 1'b1)
        else $error("error count missed a nibble");
    AST_GAP_SHORT: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_gap_end ##0 !pattern_gap_sel) |-> low_run_q == 10'(GAP_SHORT))
        else $error("short gap has wrong length");
    AST_GAP_LONG: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_gap_end ##0 pattern_gap_sel) |-> low_run_q == 10'(GAP_LONG))
        else $error("long gap has wrong length");
    AST_BURST: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_burst_end |-> high_run_q == 10'(SEQ_CYC))
        else $error("pattern burst has wrong length");
    AST_KIND: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce |=> pattern_kind_q == $past(driver_pattern_choice))
        else $error("pattern kind not following choice");
endmodule

//--- src/tbbc_pkg.sv
// constants shared by the 10 Mb/s test pattern and self-test control block
package tbbc_pkg;
    // register indices on the management register port
    localparam logic [4:0]  TBBC_OFS_TENBASE_SC  = 5'h1a;
    localparam logic [4:0]  TBBC_OFS_DRV_TEST    = 5'h1b;
    // field positions, status/control register
    localparam int          TBBC_SC_GUARD_OFF    = 0;
    localparam int          TBBC_SC_SQE_OFF      = 1;
    localparam int          TBBC_SC_RSVD_ONE     = 2;
    // field positions, driver test / self-test register
    localparam int          TBBC_DT_CHOICE_LO    = 0;
    localparam int          TBBC_DT_GAP_SEL      = 2;
    localparam int          TBBC_DT_PATT_ON      = 4;
    localparam int          TBBC_DT_NONSTOP      = 5;
    localparam int          TBBC_DT_ERRCNT_LO    = 8;
    // reset values
    localparam logic [2:0]  TBBC_SC_RESET        = 3'h4;
    localparam logic [5:0]  TBBC_DT_RESET        = 6'h00;
    localparam logic [15:0] TBBC_RDATA_RESET     = 16'h0000;
    // pattern choice encodings
    localparam logic [1:0]  TBBC_PAT_DATA_EOP_A  = 2'h0;
    localparam logic [1:0]  TBBC_PAT_DATA_EOP_B  = 2'h1;
    localparam logic [1:0]  TBBC_PAT_LINK_PULSE  = 2'h2;
    localparam logic [1:0]  TBBC_PAT_MANCH_ONES  = 2'h3;
    // timing
    localparam int          TBBC_CLK_PERIOD_PS   = 40000;
    localparam int          TBBC_GAP_LONG_US     = 15;
    localparam int          TBBC_GAP_SHORT_US    = 10;
    localparam int          TBBC_GAP_LONG_CYC    =
        (TBBC_GAP_LONG_US * 1000000 + TBBC_CLK_PERIOD_PS - 1) / TBBC_CLK_PERIOD_PS;
    localparam int          TBBC_GAP_SHORT_CYC   =
        (TBBC_GAP_SHORT_US * 1000000 + TBBC_CLK_PERIOD_PS - 1) / TBBC_CLK_PERIOD_PS;
    localparam int          TBBC_SEQ_CYC         = 64;
    // pattern sequencer states
    typedef enum logic [1:0] {TBBC_ST_IDLE, TBBC_ST_SEND, TBBC_ST_GAP} tbbc_state_t;
endpackage

//--- src/tbbc_pattern_seq.sv
// common-driver test pattern sequencer: sequence bursts separated by idle gaps
`timescale 1ns/1ps
module tbbc_pattern_seq
    import tbbc_pkg::*;
#(
    parameter int SEQ_CYC   = TBBC_SEQ_CYC,
    parameter int GAP_LONG  = TBBC_GAP_LONG_CYC,
    parameter int GAP_SHORT = TBBC_GAP_SHORT_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       driver_pattern_on,
    input  wire logic       pattern_gap_sel,
    input  wire logic [1:0] driver_pattern_choice,
    output logic            pattern_send_q,
    output logic [1:0]      pattern_kind_q
);
    localparam int CW = 10;
    tbbc_state_t   state_q;
    logic [CW-1:0] cnt_q;

    // sequencer; constant ones have no gaps so they stay in send
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q        <= TBBC_ST_IDLE;
            cnt_q          <= '0;
            pattern_send_q <= 1'b0;
            pattern_kind_q <= TBBC_PAT_DATA_EOP_A;
        end else if (ce) begin
            pattern_kind_q <= driver_pattern_choice;
            if (!driver_pattern_on) begin
                state_q        <= TBBC_ST_IDLE;
                cnt_q          <= '0;
                pattern_send_q <= 1'b0;
            end else begin
                case (state_q)
                    TBBC_ST_IDLE: begin
                        state_q        <= TBBC_ST_SEND;
                        cnt_q          <= CW'(SEQ_CYC - 1);
                        pattern_send_q <= 1'b1;
                    end
                    TBBC_ST_SEND: begin
                        if (driver_pattern_choice == TBBC_PAT_MANCH_ONES) begin
                            cnt_q <= CW'(SEQ_CYC - 1);
                        end else if (cnt_q == '0) begin
                            state_q        <= TBBC_ST_GAP;
                            pattern_send_q <= 1'b0;
                            // gap loaded one short and counted down to zero so idle lasts exactly the gap
                            cnt_q <= pattern_gap_sel ? CW'(GAP_LONG - 1)
                                                     : CW'(GAP_SHORT - 1);
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    TBBC_ST_GAP: begin
                        if (cnt_q == '0) begin
                            state_q        <= TBBC_ST_SEND;
                            cnt_q          <= CW'(SEQ_CYC - 1);
                            pattern_send_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    default: begin
                        state_q        <= TBBC_ST_IDLE;
                        pattern_send_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // a disabled pattern is never on the wire
    AST_PATT_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ce && !driver_pattern_on) |=> !pattern_send_q)
        else $error("pattern sent while disabled");
endmodule

//--- tb/tbbc_ctrl_bench.sv
// self-checking bench for the 10 Mb/s test pattern and self-test control block
`timescale 1ns/1ps
module tbbc_ctrl_bench;
    import tbbc_pkg::*;
    // shortened counts keep the pattern tests to a few hundred cycles
    localparam int SEQ = 8;
    localparam int GL  = 8;
    localparam int GS  = 5;
    localparam int LIMIT = 20000;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        ce = 1'b1;
    logic        mgmt_wr = 1'b0;
    logic        mgmt_rd = 1'b0;
    logic [4:0]  mgmt_addr = 5'h00;
    logic [15:0] mgmt_wdata = 16'h0000;
    logic [15:0] mgmt_rdata_q;
    logic        speed_100 = 1'b0;
    logic        full_duplex = 1'b0;
    logic        selftest_run = 1'b0;
    logic        selftest_start = 1'b0;
    logic        rx_nibble_err = 1'b0;
    logic        sqe_enable_q;
    logic        jabber_enable_q;
    logic        selftest_nonstop_tx_q;
    logic        pattern_send_q;
    logic [1:0]  pattern_kind_q;
    int          err_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          hi;
    int          lo;

    tbbc_ctrl #(.ERR_W(8), .SEQ_CYC(SEQ), .GAP_LONG(GL), .GAP_SHORT(GS)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata_q(mgmt_rdata_q), .speed_100(speed_100), .full_duplex(full_duplex),
        .selftest_run(selftest_run), .selftest_start(selftest_start),
        .rx_nibble_err(rx_nibble_err), .sqe_enable_q(sqe_enable_q),
        .jabber_enable_q(jabber_enable_q), .selftest_nonstop_tx_q(selftest_nonstop_tx_q),
        .pattern_send_q(pattern_send_q), .pattern_kind_q(pattern_kind_q));

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    // hang guard: a stuck wait counts as a mismatch
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_wr = 1'b1;
        mgmt_addr = a;
        mgmt_wdata = d;
        tick();
        mgmt_wr = 1'b0;
        tick(); // idle edge so a following call never rewrites the strobe in one step
    endtask

    // read data is registered at the strobe edge
    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string nm);
        mgmt_rd = 1'b1;
        mgmt_addr = a;
        tick();
        mgmt_rd = 1'b0;
        chk(nm, mgmt_rdata_q, exp);
        tick();
    endtask

    task automatic errs(input int n);
        repeat (n) begin
            rx_nibble_err = 1'b1;
            tick();
            rx_nibble_err = 1'b0;
            tick();
        end
    endtask

    // bounded waits: one full burst then one full gap
    task automatic meas(output int h, output int l);
        int k;
        h = 0;
        l = 0;
        for (k = 0; k < 100 && pattern_send_q !== 1'b1; k++) tick();
        while (pattern_send_q === 1'b1 && h < 100) begin
            h++;
            tick();
        end
        while (pattern_send_q === 1'b0 && l < 100) begin
            l++;
            tick();
        end
    endtask

    initial begin
        tick(12);
        chk("outputs in reset", 16'({sqe_enable_q, jabber_enable_q, selftest_nonstop_tx_q,
            pattern_send_q, pattern_kind_q}), 16'h0000);
        arst_n = 1'b1;
        tick(2);
        rd(TBBC_OFS_TENBASE_SC, 16'h0004, "status reset");
        rd(TBBC_OFS_DRV_TEST, 16'h0000, "drvtest reset");
        wr(5'h1c, 16'hffff);
        rd(5'h1c, 16'h0000, "unmapped");
        // frozen clock enable must drop the write
        ce = 1'b0;
        wr(TBBC_OFS_TENBASE_SC, 16'h0007);
        ce = 1'b1;
        rd(TBBC_OFS_TENBASE_SC, 16'h0004, "ce freeze");
        $display("test registers done");

        // speed, duplex and both disable bits over all combinations
        for (int i = 0; i < 16; i++) begin
            speed_100 = i[3];
            full_duplex = i[2];
            wr(TBBC_OFS_TENBASE_SC, 16'h0004 | 16'(i[1:0]));
            tick();
            chk("heartbeat", 16'(sqe_enable_q), 16'(!i[3] && !i[2] && !i[1]));
            chk("jabber", 16'(jabber_enable_q), 16'(!i[3] && !i[0]));
        end
        speed_100 = 1'b0;
        full_duplex = 1'b0;
        rd(TBBC_OFS_TENBASE_SC, 16'h0007, "status readback");
        $display("test heartbeat jabber done");

        // jabber guard already off before the gapless stream
        wr(TBBC_OFS_TENBASE_SC, 16'h0005);
        wr(TBBC_OFS_DRV_TEST, 16'h0020);
        tick();
        chk("nonstop no run", 16'(selftest_nonstop_tx_q), 16'h0000);
        selftest_run = 1'b1;
        tick(2);
        chk("nonstop run", 16'(selftest_nonstop_tx_q), 16'h0001);
        selftest_start = 1'b1;
        tick();
        selftest_start = 1'b0;
        errs(3);
        rd(TBBC_OFS_DRV_TEST, 16'h0320, "err count");
        wr(TBBC_OFS_DRV_TEST, 16'hff20);
        rd(TBBC_OFS_DRV_TEST, 16'h0320, "count read only");
        errs(300);
        rd(TBBC_OFS_DRV_TEST, 16'hff20, "saturate");
        selftest_start = 1'b1;
        rx_nibble_err = 1'b1;
        tick();
        selftest_start = 1'b0;
        rx_nibble_err = 1'b0;
        rd(TBBC_OFS_DRV_TEST, 16'h0020, "restart clear");
        selftest_run = 1'b0;
        errs(2);
        rd(TBBC_OFS_DRV_TEST, 16'h0020, "count idle");
        wr(TBBC_OFS_DRV_TEST, 16'h0000);
        $display("test self-test done");

        // every pattern choice under both gap settings
        for (int g = 0; g < 2; g++) begin
            for (int c = 0; c < 4; c++) begin
                tick(3);
                chk("send when off", 16'(pattern_send_q), 16'h0000);
                wr(TBBC_OFS_DRV_TEST, 16'h0010 | 16'(g << 2) | 16'(c));
                if (c == 3) begin
                    tick(2);
                    hi = 0;
                    repeat (40) begin
                        hi += int'(pattern_send_q === 1'b1);
                        tick();
                    end
                    chk("ones steady", 16'(hi), 16'd40);
                end else begin
                    meas(hi, lo);
                    chk("burst length", 16'(hi), 16'(SEQ));
                    chk("gap length", 16'(lo), 16'(g ? GL : GS));
                end
                chk("pattern kind", 16'(pattern_kind_q), 16'(c));
                wr(TBBC_OFS_DRV_TEST, 16'h0000);
                tick();
                chk("send off", 16'(pattern_send_q), 16'h0000);
            end
        end
        $display("test patterns done");
        results();
    end
endmodule
